// File: aecc_pkg.sv
/*
  Package of the error counter command unit: register offsets, command codes,
  response layout, counter sizes and reset values, shared types.
  Assumes one system clock; event sources and the bus master share it.
*/
// Function
// [R1] Command 4B reads line counters and bitmap.
// [R2] Clearing read answers like non-clearing read.
// [R3] After clearing read, every counter becomes zero; 4d keeps the line counters and bitmap, 4b counts a pulse of its own cycle.
// [R4] Six 32-bit summators in bytes 4 to 27.
// [R5] Power-fail and ground-short counts in bytes 0-3.
// [R6] Bytes 28-35 flag slaves that had errors.
// [R7] Command 4C with slave address reads one slave.
// [R8] Separate counter set per slave address.
// [R9] Slave failure, missing, bad frame in bytes 0-5.
// [R10] I/O, protocol, bad master in bytes 6-11.
// [R11] Count slave removed from activated slave list.
// [R12] Count missing response of present slave.
// [R13] Count corrupted slave response.
// [R14] Count peripheral fault in status answer.
// [R15] Count protocol transfer errors.
// [R16] Optionally count bad master frames.
// [R17] Non-clearing slave read leaves counters unchanged.
// [R18] Counters saturate instead of wrapping.
package aecc_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_RESP     = 8'h10;
  localparam logic [7:0] OFS_RESP_END = 8'h30;

  // Command codes.
  localparam logic [7:0] CMD_LINE_RD     = 8'h4a;
  localparam logic [7:0] CMD_LINE_RD_CLR = 8'h4b;
  localparam logic [7:0] CMD_SLV_RD      = 8'h4c;
  localparam logic [7:0] CMD_SLV_RD_CLR  = 8'h4d;

  // Field positions.
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_ERR      = 1;

  // Sizes and response layout.
  localparam int NUM_SLAVES  = 64;
  localparam int NUM_KINDS   = 6;
  localparam int CNT_W       = 16;
  localparam int SUM_W       = 32;
  localparam int RESP_BYTES  = 36;
  localparam int BYTE_PWR    = 0;
  localparam int BYTE_GND    = 2;
  localparam int BYTE_SUM    = 4;
  localparam int BYTE_BITMAP = 28;

  // Reset value and last sweep index.
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [5:0] CLR_IDX_LAST = 6'h3f;

  // Event kinds, one bit each: 0 slave failure, 1 missing frame, 2 bad slave
  // frame, 3 I/O error, 4 protocol error, 5 bad master frame.
  typedef struct packed {
    logic [5:0] kind;
    logic [5:0] addr;
  } aecc_evt_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EVRD,
    ST_SLRD,
    ST_CLR
  } aecc_state_t;

endpackage : aecc_pkg

// File: aecc_mem.sv
/*
  Per-slave counter memory: one word of six 16-bit counters per slave address.
  Assumes the caller clears every word after reset before trusting the data.
*/
`timescale 1ns/1ps
`default_nettype none
module aecc_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6,
  parameter int DW    = 96
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [DEPTH];

  // Write port.
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Registered read port, one cycle after the address.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule : aecc_mem
`default_nettype wire

// File: aecc_top.sv
/*
  Error counter command unit. Keeps line-wide counters, a per-slave error
  bitmap and per-slave counters, and serves line and per-slave read commands
  issued over APB. Responses are read back from a response window.

  Register map, one aligned 32-bit word each:
    0x00 command: bits 7 to 0 hold the code, bits 13 to 8 the slave address.
    0x04 status: bit 0 command pending, bit 1 sequencer busy.
    0x08 interrupt status: bit 0 done, bit 1 error; a written one clears.
    0x0c interrupt mask: same layout as the status, zero after reset.
    0x10 to 0x30 response window: nine words, lowest byte in the top lane.

  Commands:
    4a reads the line counters and the bitmap and leaves them as they are.
    4b reads the same content, then zeroes the line counters, the bitmap
       and every per-slave counter set.
    4c reads the six counters of one slave address.
    4d reads one slave's counters, then zeroes every per-slave counter set.
    Any other code sets the error interrupt bit and changes nothing else.

  Timing:
    The APB slave inserts no wait state: ready rises in the access cycle.
    An accepted event holds event ready low for one cycle while the counter
    word of its slave is read, incremented and written back.
    A clearing command sweeps all 64 memory words, one word per cycle.
    Reset starts the same sweep, so events stall for 64 cycles after it;
    a command written during that sweep waits and runs after it.

  Assumes event strobes come from logic on the same clock, one per cycle at
  most, and that the APB master follows the usual two-phase protocol.
  The power-fail and ground-short inputs are single-cycle pulses from logic
  on the same clock; each high cycle counts once.
*/
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module aecc_top (
  input  wire logic                I_CLK,
  input  wire logic                I_RST_B,
  input  wire logic                I_PSEL,
  input  wire logic                I_PENABLE,
  input  wire logic                I_PWRITE,
  input  wire logic [7:0]          I_PADDR,
  input  wire logic [31:0]         I_PWDATA,
  output logic      [31:0]         O_PRDATA,
  output logic                     O_PREADY,
  output logic                     O_PSLVERR,
  input  wire logic                I_EVT_VALID,
  input  wire aecc_pkg::aecc_evt_t I_EVT,
  output logic                     O_EVT_READY,
  input  wire logic                I_POWER_FAIL,
  input  wire logic                I_GROUND_SHORT,
  output logic                     O_IRQ
);

  localparam int MW = aecc_pkg::NUM_KINDS * aecc_pkg::CNT_W;

  typedef struct packed {
    aecc_pkg::aecc_state_t st;
    logic [5:0]            idx;
    logic                  cmd_pend;
    logic                  sweep_own;
    logic [7:0]            cmd;
    logic [5:0]            addr;
    aecc_pkg::aecc_evt_t   ev;
    logic [15:0]           pwr;
    logic [15:0]           gnd;
    logic [5:0][31:0]      sum;
    logic [63:0]           bmap;
    logic [35:0][7:0]      resp;
    logic [1:0]            ists;
    logic [1:0]            imask;
    logic                  irq;
    logic                  ready;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } aecc_core_t;

  aecc_core_t r;
  aecc_core_t n;

  logic          evt_take;
  logic [31:0]   rword;
  logic          rhit;
  logic [7:0]    widx;
  logic          mem_we;
  logic [5:0]    mem_waddr;
  logic [MW-1:0] mem_wdata;
  logic [5:0]    mem_raddr;
  logic [MW-1:0] mem_rdata;
  logic [15:0]   cnt;

  // Per-slave counter storage, a separate set for every address.
  // One word holds the six 16-bit counters of a slave, so an event costs a
  // single read and a single write. The read data are registered, which is
  // why an event and a slave read each spend one cycle waiting for the word.
  aecc_mem #(
    .DEPTH (aecc_pkg::NUM_SLAVES),
    .AW    (6),
    .DW    (MW)
  ) u_mem (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_raddr (mem_raddr),
    .o_rdata (mem_rdata)
  ); // [R8]

  // An event is taken only while the unit is idle with no command waiting.
  // Stalling events during a command keeps the snapshot and the clear in step,
  // so no event can slip in between reading a counter and zeroing it.
  assign evt_take = I_EVT_VALID & r.ready;

  // Memory read address: the commanded slave, the arriving event, or the held event.
  // The arriving event's address is presented while idle so that the word is
  // already in the read register when the increment cycle starts.
  always_comb begin
    if (r.st == aecc_pkg::ST_IDLE) begin
      mem_raddr = r.cmd_pend ? r.addr : I_EVT.addr;
    end else begin
      mem_raddr = r.ev.addr;
    end
  end

  // Memory write: saturating increments after an event, zeros while sweeping.
  // All six counters of the word are rewritten; those whose kind bit is clear
  // are written back unchanged. A counter at its top value stays there.
  // The sweep writes one address per cycle and owns the port while it runs.
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = r.ev.addr;
    mem_wdata = mem_rdata;
    cnt       = '0;
    if (r.st == aecc_pkg::ST_EVRD) begin
      mem_we = 1'b1;
      for (int k = 0; k < aecc_pkg::NUM_KINDS; k++) begin
        cnt = mem_rdata[k*aecc_pkg::CNT_W +: aecc_pkg::CNT_W];
        if (r.ev.kind[k] && cnt != 16'hffff) begin // [R18]
          cnt = cnt + 16'h0001; // [R11] [R12] [R13] [R14] [R15] [R16]
        end
        mem_wdata[k*aecc_pkg::CNT_W +: aecc_pkg::CNT_W] = cnt;
      end
    end else if (r.st == aecc_pkg::ST_CLR) begin
      mem_we    = 1'b1;
      mem_waddr = r.idx;
      mem_wdata = '0; // [R3]
    end
  end

  // Register read decode, sampled in the setup phase.
  // The word is captured at the setup edge, so the data stand through the
  // access cycle without depending on the address held by the master.
  // Unmapped or unaligned addresses read as zero and raise the error response.
  always_comb begin
    rword = '0;
    rhit  = 1'b1;
    widx  = (I_PADDR - aecc_pkg::OFS_RESP) >> 2;
    if (I_PADDR == aecc_pkg::OFS_CMD) begin
      rword = {18'h0, r.addr, r.cmd};
    end else if (I_PADDR == aecc_pkg::OFS_STATUS) begin
      rword = {30'h0, r.st != aecc_pkg::ST_IDLE, r.cmd_pend};
    end else if (I_PADDR == aecc_pkg::OFS_IRQ_STAT) begin
      rword = {30'h0, r.ists};
    end else if (I_PADDR == aecc_pkg::OFS_IRQ_MASK) begin
      rword = {30'h0, r.imask};
    end else if (I_PADDR >= aecc_pkg::OFS_RESP && I_PADDR <= aecc_pkg::OFS_RESP_END
                 && I_PADDR[1:0] == 2'h0) begin
      // Byte 4w of the response lands in the top lane: high byte first.
      rword = {r.resp[widx*4], r.resp[widx*4+1], r.resp[widx*4+2], r.resp[widx*4+3]};
    end else begin
      rhit = 1'b0;
    end
  end

  // Next-state logic for the whole unit.
  // Every register of the unit lives in one struct, so this process starts
  // from the present state and changes only what each part needs.
  // Later assignments win: flags that the sequencer sets below therefore
  // take priority over a software clear in the same cycle.
  always_comb begin
    n = r;

    // Bus slave: answer one cycle after setup with registered data.
    // A write acts only at the access edge, and only on a mapped address,
    // so a refused access never changes state.
    n.pready = I_PSEL & ~I_PENABLE;
    if (I_PSEL && !I_PENABLE) begin
      n.prdata  = I_PWRITE ? 32'h0 : rword;
      n.pslverr = ~rhit;
    end
    if (I_PSEL && I_PENABLE && r.pready && I_PWRITE && !r.pslverr) begin
      if (I_PADDR == aecc_pkg::OFS_CMD) begin
        if (r.cmd_pend) begin
          n.ists[aecc_pkg::IRQ_ERR] = 1'b1;
        end else begin
          n.cmd_pend = 1'b1;
          n.cmd      = I_PWDATA[aecc_pkg::CMD_CODE_LSB +: 8];
          n.addr     = I_PWDATA[aecc_pkg::CMD_ADDR_LSB +: 6];
        end
      end else if (I_PADDR == aecc_pkg::OFS_IRQ_STAT) begin
        n.ists = r.ists & ~I_PWDATA[1:0];
      end else if (I_PADDR == aecc_pkg::OFS_IRQ_MASK) begin
        n.imask = I_PWDATA[1:0];
      end
    end

    // Line-wide counters and bitmap follow every accepted event.
    // The power-fail and ground-short pulses are never stalled, so they are
    // counted here in every state, sweeps included.
    if (I_POWER_FAIL && r.pwr != 16'hffff) begin
      n.pwr = r.pwr + 16'h0001; // [R18]
    end
    if (I_GROUND_SHORT && r.gnd != 16'hffff) begin
      n.gnd = r.gnd + 16'h0001; // [R18]
    end
    for (int k = 0; k < aecc_pkg::NUM_KINDS; k++) begin
      if (evt_take && I_EVT.kind[k] && r.sum[k] != 32'hffffffff) begin
        n.sum[k] = r.sum[k] + 32'h00000001; // [R11] [R12] [R13] [R14] [R15] [R16] [R18]
      end
    end
    if (evt_take && I_EVT.kind != 6'h00) begin
      n.bmap[I_EVT.addr] = 1'b1; // [R6]
    end

    // Command and event sequencing.
    // A pending command is served before any new event. Line reads snapshot
    // the counters in one cycle; slave reads wait one cycle for the memory
    // word. The clearing commands then hand over to the sweep, which marks
    // the command done only if the command itself started it.
    case (r.st)
      aecc_pkg::ST_IDLE: begin
        if (r.cmd_pend) begin
          if (r.cmd == aecc_pkg::CMD_LINE_RD || r.cmd == aecc_pkg::CMD_LINE_RD_CLR) begin // [R1] [R2]
            n.resp = '0;
            n.resp[aecc_pkg::BYTE_PWR]     = r.pwr[15:8]; // [R5]
            n.resp[aecc_pkg::BYTE_PWR + 1] = r.pwr[7:0];
            n.resp[aecc_pkg::BYTE_GND]     = r.gnd[15:8];
            n.resp[aecc_pkg::BYTE_GND + 1] = r.gnd[7:0];
            for (int k = 0; k < aecc_pkg::NUM_KINDS; k++) begin
              for (int b = 0; b < 4; b++) begin
                n.resp[aecc_pkg::BYTE_SUM + 4*k + b] = r.sum[k][31-8*b -: 8]; // [R4]
              end
            end
            for (int s = 0; s < aecc_pkg::NUM_SLAVES; s++) begin
              n.resp[aecc_pkg::BYTE_BITMAP + s/8][7 - s%8] = r.bmap[s]; // [R6]
            end
            if (r.cmd == aecc_pkg::CMD_LINE_RD_CLR) begin
              // Values were captured above; a power-fail or ground-short pulse of this cycle survives the clear.
              n.pwr  = {15'h0, I_POWER_FAIL}; // [R3]
              n.gnd  = {15'h0, I_GROUND_SHORT};
              n.bmap = '0;
              n.sum  = '0;
              n.sweep_own = 1'b1;
              n.idx  = '0;
              n.st   = aecc_pkg::ST_CLR;
            end else begin
              n.cmd_pend                 = 1'b0;
              n.ists[aecc_pkg::IRQ_DONE] = 1'b1;
            end
          end else if (r.cmd == aecc_pkg::CMD_SLV_RD || r.cmd == aecc_pkg::CMD_SLV_RD_CLR) begin // [R7]
            n.st = aecc_pkg::ST_SLRD;
          end else begin
            n.cmd_pend                = 1'b0;
            n.ists[aecc_pkg::IRQ_ERR] = 1'b1;
          end
        end else if (evt_take) begin
          n.ev = I_EVT;
          n.st = aecc_pkg::ST_EVRD;
        end
      end
      aecc_pkg::ST_EVRD: begin
        n.st = aecc_pkg::ST_IDLE;
      end
      // The addressed word stands in the read register now; copy it out,
      // high byte first, and leave the counters as they are.
      aecc_pkg::ST_SLRD: begin
        n.resp = '0;
        for (int k = 0; k < aecc_pkg::NUM_KINDS; k++) begin
          n.resp[2*k]     = mem_rdata[k*aecc_pkg::CNT_W + 8 +: 8]; // [R9] [R10]
          n.resp[2*k + 1] = mem_rdata[k*aecc_pkg::CNT_W +: 8];
        end
        if (r.cmd == aecc_pkg::CMD_SLV_RD_CLR) begin
          n.idx = '0;
          n.st  = aecc_pkg::ST_CLR;
          n.sweep_own = 1'b1;
        end else begin
          n.st                       = aecc_pkg::ST_IDLE; // [R17]
          n.cmd_pend                 = 1'b0;
          n.ists[aecc_pkg::IRQ_DONE] = 1'b1;
        end
      end
      // Sweep of the slave memory, one word per cycle. After reset no command
      // owns it, and a command queued meanwhile must still run once the sweep
      // is over instead of being marked done unserved.
      aecc_pkg::ST_CLR: begin
        n.idx = r.idx + 6'h01;
        if (r.idx == aecc_pkg::CLR_IDX_LAST) begin
          n.st = aecc_pkg::ST_IDLE;
          if (r.sweep_own) begin
            n.sweep_own                = 1'b0;
            n.cmd_pend                 = 1'b0;
            n.ists[aecc_pkg::IRQ_DONE] = 1'b1; // [R3]
          end
        end
      end
      default: begin
        n.st = aecc_pkg::ST_IDLE;
      end
    endcase

    n.ready = (n.st == aecc_pkg::ST_IDLE) & ~n.cmd_pend;
    n.irq   = |(n.ists & n.imask);
  end

  // State register; reset starts a sweep that zeroes the slave memory.
  // The memory itself has no reset, so its contents are not trusted until
  // this sweep has written every word.
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      r       <= '0;
      r.st    <= aecc_pkg::ST_CLR;
      r.imask <= aecc_pkg::IRQ_MASK_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register.
  // No output passes through logic after the flip-flop, so the pins carry
  // no glitches and their timing does not depend on the inputs.
  assign O_PRDATA    = r.prdata;
  assign O_PREADY    = r.pready;
  assign O_PSLVERR   = r.pslverr;
  assign O_EVT_READY = r.ready;
  assign O_IRQ       = r.irq;

endmodule : aecc_top
`default_nettype wire

// File: aecc_assertions.sv
/*
  Port checker of the error counter command unit.
  Assumes it is bound to aecc_top and shares its clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module aecc_assertions (
  input wire logic                I_CLK,
  input wire logic                I_RST_B,
  input wire logic                I_PSEL,
  input wire logic                I_PENABLE,
  input wire logic                I_PWRITE,
  input wire logic [7:0]          I_PADDR,
  input wire logic [31:0]         I_PWDATA,
  input wire logic [31:0]         O_PRDATA,
  input wire logic                O_PREADY,
  input wire logic                O_PSLVERR,
  input wire logic                I_EVT_VALID,
  input wire aecc_pkg::aecc_evt_t I_EVT,
  input wire logic                O_EVT_READY,
  input wire logic                I_POWER_FAIL,
  input wire logic                I_GROUND_SHORT,
  input wire logic                O_IRQ
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  logic setup;
  logic bad_adr;

  // Setup phase and unmapped address decode.
  assign setup   = I_PSEL & ~I_PENABLE;
  assign bad_adr = (I_PADDR > 8'h30) | (I_PADDR[1:0] != 2'h0);

  a_ready_answer: assert property (setup |=> O_PREADY) else $error("pready missing");
  a_ready_single: assert property (O_PREADY |=> !O_PREADY) else $error("pready held");
  a_rdata_hold: assert property (O_PREADY |=> $stable(O_PRDATA)) else $error("rdata moved");
  a_err_unmapped: assert property (setup && bad_adr |=> O_PSLVERR) else $error("no slverr");
  a_err_mapped: assert property (setup && !bad_adr |=> !O_PSLVERR) else $error("bad slverr");
  a_rd_zero: assert property (setup && !I_PWRITE && bad_adr |=> O_PRDATA == 32'h0)
    else $error("unmapped data");
  a_evt_take: assert property (I_EVT_VALID && O_EVT_READY |=> !O_EVT_READY) else $error("ready held");
  a_sweep_stall: assert property ($rose(I_RST_B) |-> !O_EVT_READY [*8]) else $error("early ready");
  a_irq_quiet: assert property ($rose(I_RST_B) |-> ##2 !O_IRQ) else $error("irq after reset");
endmodule : aecc_assertions

bind aecc_top aecc_assertions i_chk (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_EVT_VALID(I_EVT_VALID),
  .I_EVT(I_EVT), .O_EVT_READY(O_EVT_READY), .I_POWER_FAIL(I_POWER_FAIL),
  .I_GROUND_SHORT(I_GROUND_SHORT), .O_IRQ(O_IRQ));
`default_nettype wire

// File: aecc_evt_src.sv
/*
  Event source model standing for the line logic that reports slave errors.
  Assumes the unit's event ready is a register on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module aecc_evt_src (
  input  wire logic                i_clk,
  input  wire logic                i_ready,
  output var  logic                o_valid,
  output var  aecc_pkg::aecc_evt_t o_evt
);
  // Idle at time zero.
  initial begin
    o_valid = 1'b0;
    o_evt   = '0;
  end

  // Offers one event, holds it until taken, then scrambles the idle bus.
  task automatic send(input logic [5:0] kind, input logic [5:0] addr);
    o_valid <= 1'b1;
    o_evt   <= '{kind: kind, addr: addr};
    do begin
      @(negedge i_clk);
    end while (i_ready !== 1'b1);
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_evt   <= aecc_pkg::aecc_evt_t'(~{kind, addr});
    @(posedge i_clk);
  endtask : send
endmodule : aecc_evt_src
`default_nettype wire

// File: test_asi_error_counter_commands.sv
/*
  Self-checking bench of the error counter unit with a counting model.
  Assumes a 40 MHz clock; the bus tasks wait for ready, the watchdog ends a hang.
*/
`timescale 1ns/1ps
`default_nettype none
module test_asi_error_counter_commands;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pf = 1'b0, gs = 1'b0;
  logic [7:0]  paddr  = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, evt_valid, evt_ready, irq;
  aecc_pkg::aecc_evt_t evt;
  int bad_count = 0, samples_checked = 0, pwr_n = 0, gnd_n = 0, cur = 0;
  int sum_n[6], slv_n[64][6];
  bit hit[64];

  // Free-running clock.
  always #12.5 clk = ~clk;

  aecc_top i_dut (.I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_EVT_VALID(evt_valid), .I_EVT(evt), .O_EVT_READY(evt_ready), .I_POWER_FAIL(pf),
    .I_GROUND_SHORT(gs), .O_IRQ(irq));
  aecc_evt_src i_src (.i_clk(clk), .i_ready(evt_ready), .o_valid(evt_valid), .o_evt(evt));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Ready and read data are taken at the rising edge that completes the access.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb

  task automatic cmd(input logic [7:0] code, input logic [5:0] a);
    apb(1'b1, aecc_pkg::OFS_CMD, {18'h0, a, code}, rd);
    do begin
      apb(1'b0, aecc_pkg::OFS_STATUS, 32'h0, rd);
    end while (rd[0] !== 1'b0);
  endtask : cmd

  // Builds the expected response bytes from the model and reads the window.
  task automatic cmp_resp(input logic line, input string what);
    logic [7:0]  b[36];
    logic [31:0] q;
    foreach (b[i]) b[i] = 8'h0;
    if (line) begin
      {b[0], b[1]} = pwr_n[15:0];
      {b[2], b[3]} = gnd_n[15:0];
      for (int k = 0; k < 6; k++) {b[4+4*k], b[5+4*k], b[6+4*k], b[7+4*k]} = sum_n[k];
      for (int s = 0; s < 64; s++) b[28+s/8][7-s%8] = hit[s];
    end else begin
      for (int k = 0; k < 6; k++) {b[2*k], b[2*k+1]} = slv_n[cur][k][15:0];
    end
    for (int w = 0; w < 9; w++) begin
      apb(1'b0, aecc_pkg::OFS_RESP + 8'(4*w), 32'h0, q);
      chk(q, {b[4*w], b[4*w+1], b[4*w+2], b[4*w+3]}, what);
    end
  endtask : cmp_resp

  // Random events plus power-fail and ground-short pulses.
  task automatic traffic(input int n);
    logic [5:0] k, a;
    repeat (n) begin
      k = 6'($urandom_range(1, 63));
      a = 6'($urandom);
      i_src.send(k, a);
      hit[a] = 1'b1;
      cur = a;
      for (int j = 0; j < 6; j++) if (k[j]) begin sum_n[j]++; slv_n[a][j]++; end
      pf <= 1'b1; gs <= $urandom_range(0, 1) == 1;
      @(posedge clk);
      pwr_n++; gnd_n += int'(gs);
      pf <= 1'b0; gs <= 1'b0;
    end
  endtask : traffic

  task automatic end_sim;
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // Watchdog.
  initial begin
    #(25 * 60000);
    bad_count++;
    end_sim();
  end

  // Main sequence.
  initial begin
    logic [31:0] q;
    void'($urandom(32'he164));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b1, aecc_pkg::OFS_IRQ_MASK, 32'h1, q);
    traffic(40);
    repeat (2) begin
      cmd(aecc_pkg::CMD_SLV_RD, 6'(cur));
      cmp_resp(1'b0, "slave word");
    end
    cmd(aecc_pkg::CMD_LINE_RD, 6'h0);
    cmp_resp(1'b1, "line word");
    chk({31'h0, irq}, 32'h1, "irq");
    apb(1'b1, aecc_pkg::OFS_IRQ_STAT, 32'h1, q);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    cmd(aecc_pkg::CMD_LINE_RD_CLR, 6'h0);
    cmp_resp(1'b1, "clear word");
    pwr_n = 0; gnd_n = 0; sum_n = '{default: 0}; slv_n = '{default: 0}; hit = '{default: 0};
    cmd(aecc_pkg::CMD_LINE_RD, 6'h0);
    cmp_resp(1'b1, "zeroed line");
    cmd(aecc_pkg::CMD_SLV_RD, 6'(cur));
    cmp_resp(1'b0, "zeroed slave");
    apb(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0, "unmapped");
    cmd(8'h55, 6'h0);
    apb(1'b0, aecc_pkg::OFS_IRQ_STAT, 32'h0, q);
    chk({31'h0, q[1]}, 32'h1, "bad code");
    end_sim();
  end
endmodule : test_asi_error_counter_commands
`default_nettype wire
